/* hdl/legacy_io_trap_capture.sv */
`timescale 1ns/10ps
`include "legacy_trap_cfg.svh"

module legacy_io_trap_capture
  import legacy_trap_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [3:0]  regBe,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  output logic             regRvalid,
  // Snooped host I/O cycles
  input  wire logic        snoopValid,
  input  wire logic [15:0] snoopAddr,
  input  wire logic        snoopWrite,
  // System
  input  wire logic        dmaConfigEnable,
  output logic             fastJoystick,
  output logic             hostIrqBlock,
  output logic             trapIrq_b
);

  default clocking checkClk @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic [15:0] ctrl_reg,   ctrl_next;
  event_num_t  event_reg,  event_next;
  logic [4:0]  addrLo_reg, addrLo_next;
  logic        dir_reg,    dir_next;
  logic        flagN_reg,  flagN_next;
  word_t       rdata_reg;
  logic        rvalid_reg;
  logic        hib_reg;
  logic        fast_reg;

  wire hit = (regAddr == `LEG_TRAP_OFFSET);
  wire wrHit = regWr & hit;
  wire rdHit = regRd & hit;

  // Byte lanes of the control half; lanes 0 and 1 hold status only.
  wire [15:0] ctrlWr = {
    regBe[3] ? regWdata[31:24] : ctrl_reg[15:8],
    regBe[2] ? regWdata[23:16] : ctrl_reg[7:0]};
  wire flagClr = wrHit & regBe[0];

  io_addr_t a;
  assign a = snoopAddr;

  wire gameSel = ctrl_reg[`GAME_RANGE_BIT-16];
  wire [1:0] baseSel = ctrl_reg[`BASE_RANGE_HI-16:`BASE_RANGE_LO-16];
  wire [1:0] codecSel = ctrl_reg[`CODEC_RANGE_HI-16:`CODEC_RANGE_LO-16];

  wire [15:0] gameLo = gameSel ? `GAME_LO_1 : `GAME_LO_0;
  wire [15:0] gameHi = gameSel ? `GAME_HI_1 : `GAME_HI_0;
  wire [15:0] baseLo = `BASE_LO_0 + 16'(baseSel) * `BASE_STEP;
  wire [15:0] codecLo = (codecSel == 2'h2) ? `CODEC_LO_2 :
                        (codecSel == 2'h3) ? `CODEC_LO_3 : `CODEC_LO_0;
  wire codecDef = (codecSel != 2'h1);

  wire inGame  = (a >= gameLo) && (a <= gameHi);
  wire inBase  = (a >= baseLo) && (a <= baseLo + `BASE_SPAN);
  wire inCodec = codecDef && (a >= codecLo) &&
                 (a <= codecLo + `CODEC_SPAN);
  wire inFm    = (a >= `FM_LO) && (a <= `FM_HI);
  wire inMintc = (a >= `MINTC_LO) && (a <= `MINTC_HI);
  wire inMdma  = (a <= `MDMA_HI);
  wire inSintc = (a >= `SINTC_LO) && (a <= `SINTC_HI);
  wire inSdma  = (a >= `SDMA_LO) && (a <= `SDMA_HI);

  // Window hits gated by their enables, indexed by event number.
  logic [7:0] inWin;
  logic [7:0] enWin;
  assign inWin = {inSdma, inSintc, inMdma, inMintc,
                  inFm, inGame, inCodec, inBase};
  assign enWin = {ctrl_reg[`SLAVE_DMA_EN_BIT-16],
                  ctrl_reg[`SLAVE_INTC_EN_BIT-16],
                  ctrl_reg[`MASTER_DMA_EN_BIT-16],
                  ctrl_reg[`MASTER_INTC_EN_BIT-16],
                  ctrl_reg[`FM_EN_BIT-16],
                  ctrl_reg[`GAME_EN_BIT-16],
                  ctrl_reg[`CODEC_EN_BIT-16],
                  ctrl_reg[`BASE_EN_BIT-16]};
  wire [7:0] trapHit = snoopValid ? (inWin & enWin) : 8'h00;

  // Windows never overlap, so at most one bit of trapHit is set.
  event_num_t hitNum;
  always_comb begin
    hitNum = `EV_BASE;
    for (int i = 0; i < 8; i++) begin
      if (trapHit[i]) begin
        hitNum = 3'(i);
      end
    end
  end

  wire anyHit = |trapHit;
  // Fields stay frozen while a capture is pending so the first event
  // survives until software has read and cleared it.
  wire capture = anyHit & (flagN_reg | flagClr);
  wire forceSet = wrHit & regBe[3] & regWdata[`FORCE_IRQ_BIT];

  always_comb begin
    ctrl_next   = wrHit ? ctrlWr : ctrl_reg;
    event_next  = capture ? hitNum : event_reg;
    addrLo_next = capture ? a[4:0] : addrLo_reg;
    dir_next    = capture ? snoopWrite : dir_reg;
    // A new event or a forced set wins over a clear in the same cycle.
    if (anyHit | forceSet) begin
      flagN_next = 1'b0;
    end else if (flagClr) begin
      flagN_next = 1'b1;
    end else begin
      flagN_next = flagN_reg;
    end
  end

  word_t readWord;
  assign readWord = {ctrl_reg, `ONES_FIELD, event_reg, addrLo_reg,
                     dir_reg, 1'b0, flagN_reg};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `CTRL_RESET;
      event_reg  <= `EV_BASE;
      addrLo_reg <= 5'h00;
      dir_reg    <= 1'b0;
      flagN_reg  <= 1'b1;
    end else begin
      ctrl_reg   <= ctrl_next;
      event_reg  <= event_next;
      addrLo_reg <= addrLo_next;
      dir_reg    <= dir_next;
      flagN_reg  <= flagN_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      hib_reg    <= 1'b0;
      fast_reg   <= 1'b0;
    end else begin
      rdata_reg  <= rdHit ? readWord : 32'h0000_0000;
      rvalid_reg <= regRd;
      hib_reg    <= ctrl_reg[`HOST_IRQ_BLOCK_BIT-16] &
                    dmaConfigEnable;
      fast_reg   <= ctrl_reg[`FAST_JOY_BIT-16];
    end
  end

  assign regRdata     = rdata_reg;
  assign regRvalid    = rvalid_reg;
  assign hostIrqBlock = hib_reg;
  assign fastJoystick = fast_reg;
  assign trapIrq_b    = flagN_reg;

  // Window checks use the fixed bounds rather than the decoder's own
  // wires, so a broken range select cannot pass by construction.
  a_game_window: assert property ((snoopValid &&
    ctrl_reg[`GAME_EN_BIT-16] && ctrl_reg[`GAME_RANGE_BIT-16] &&
    snoopAddr >= `GAME_LO_1 && snoopAddr <= `GAME_HI_1) |=> !trapIrq_b)
    else $error("game window trap missed");

  a_game_low: assert property ((snoopValid &&
    ctrl_reg[`GAME_EN_BIT-16] && !ctrl_reg[`GAME_RANGE_BIT-16] &&
    snoopAddr >= `GAME_LO_0 && snoopAddr <= `GAME_HI_0) |=> !trapIrq_b)
    else $error("low game window trap missed");

  a_game_other: assert property ((ctrl_reg[`GAME_RANGE_BIT-16] &&
    snoopAddr >= `GAME_LO_0 && snoopAddr <= `GAME_HI_0) |->
    !trapHit[`EV_GAME])
    else $error("unselected game window trapped");

  a_base_high: assert property ((snoopValid && baseSel == 2'h3 &&
    ctrl_reg[`BASE_EN_BIT-16] && snoopAddr >= `BASE_LO_3 &&
    snoopAddr <= `BASE_LO_3 + `BASE_SPAN) |=> !trapIrq_b)
    else $error("base window three trap missed");

  a_base_trap: assert property ((snoopValid && baseSel == 2'h1 &&
    ctrl_reg[`BASE_EN_BIT-16] && snoopAddr >= `BASE_LO_1 &&
    snoopAddr <= `BASE_LO_1 + `BASE_SPAN) |=> !trapIrq_b)
    else $error("base window one trap missed");

  a_codec_high: assert property ((snoopValid && codecSel == 2'h3 &&
    ctrl_reg[`CODEC_EN_BIT-16] && snoopAddr >= `CODEC_LO_3 &&
    snoopAddr <= `CODEC_LO_3 + `CODEC_SPAN) |=> !trapIrq_b)
    else $error("codec high window trap missed");

  a_codec_trap: assert property ((snoopValid && codecSel == 2'h0 &&
    ctrl_reg[`CODEC_EN_BIT-16] && snoopAddr >= `CODEC_LO_0 &&
    snoopAddr <= `CODEC_LO_0 + `CODEC_SPAN) |=> !trapIrq_b)
    else $error("codec low window trap missed");

  a_codec_undef: assert property ((codecSel == 2'h1) |->
    !trapHit[`EV_CODEC])
    else $error("undefined codec range trapped");

  a_sdma_trap: assert property ((snoopValid &&
    ctrl_reg[`SLAVE_DMA_EN_BIT-16] && snoopAddr >= `SDMA_LO &&
    snoopAddr <= `SDMA_HI) |=> !trapIrq_b)
    else $error("slave DMA access not trapped");

  a_sintc_trap: assert property ((snoopValid &&
    ctrl_reg[`SLAVE_INTC_EN_BIT-16] && snoopAddr >= `SINTC_LO &&
    snoopAddr <= `SINTC_HI) |=> !trapIrq_b)
    else $error("slave interrupt access not trapped");

  a_mdma_trap: assert property ((snoopValid &&
    ctrl_reg[`MASTER_DMA_EN_BIT-16] && snoopAddr <= `MDMA_HI) |=>
    !trapIrq_b)
    else $error("master DMA access not trapped");

  a_mintc_trap: assert property ((snoopValid &&
    ctrl_reg[`MASTER_INTC_EN_BIT-16] && snoopAddr >= `MINTC_LO &&
    snoopAddr <= `MINTC_HI) |=> !trapIrq_b)
    else $error("master interrupt access not trapped");

  a_fm_trap: assert property ((snoopValid &&
    ctrl_reg[`FM_EN_BIT-16] && snoopAddr >= `FM_LO &&
    snoopAddr <= `FM_HI) |=> !trapIrq_b)
    else $error("FM access not trapped");

  a_disabled_quiet: assert property ((trapIrq_b && !(|trapHit) &&
    !forceSet) |=> trapIrq_b)
    else $error("flag raised without enabled hit");

  a_status_frozen: assert property (!capture |=>
    $stable(event_reg) && $stable(addrLo_reg) && $stable(dir_reg))
    else $error("status fields changed without a capture");

  a_flag_clear: assert property ((flagClr && !anyHit &&
    !forceSet) |=> trapIrq_b)
    else $error("write to flag did not clear it");

  a_force_irq: assert property (forceSet |=> !trapIrq_b)
    else $error("forced interrupt not raised");

  a_hold_fields: assert property ((!trapIrq_b && !flagClr) |=>
    $stable(event_reg) && $stable(addrLo_reg))
    else $error("captured fields changed while pending");

  a_capture_addr: assert property (capture |=>
    (addrLo_reg == $past(snoopAddr[4:0]) && dir_reg == $past(snoopWrite)))
    else $error("captured address or direction wrong");

  a_mdma_event: assert property ((capture &&
    trapHit[`EV_MASTER_DMA]) |=> event_reg == `EV_MASTER_DMA)
    else $error("master DMA event number wrong");

  a_event_sdma: assert property ((capture &&
    trapHit[`EV_SLAVE_DMA]) |=> event_reg == `EV_SLAVE_DMA)
    else $error("slave DMA event number wrong");

  a_fixed_bits: assert property (rdHit |=>
    (regRdata[15:11] == `ONES_FIELD && regRdata[1] == 1'b0))
    else $error("fixed read bits wrong");

  a_rdata_ctrl: assert property (rdHit |=>
    regRdata[31:16] == $past(ctrl_reg))
    else $error("control half not returned on read");

  a_ctrl_lane: assert property ((wrHit && regBe[3]) |=>
    ctrl_reg[15:8] == $past(regWdata[31:24]))
    else $error("control byte not written");

  a_lane_ignore: assert property ((!wrHit ||
    (!regBe[3] && !regBe[2])) |=> $stable(ctrl_reg))
    else $error("control changed without a control write");

  a_unmapped_zero: assert property ((regRd && !rdHit) |=>
    regRdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_rvalid_pulse: assert property (1'b1 |=>
    regRvalid == $past(regRd))
    else $error("read answer pulse wrong");

  a_fast_copy: assert property (1'b1 |=>
    fastJoystick == $past(ctrl_reg[`FAST_JOY_BIT-16]))
    else $error("fast joystick output wrong");

  a_hib_gate: assert property (!dmaConfigEnable |=> !hostIrqBlock)
    else $error("blocking active without DMA config");

  a_hib_set: assert property ((ctrl_reg[`HOST_IRQ_BLOCK_BIT-16] &&
    dmaConfigEnable) |=> hostIrqBlock)
    else $error("blocking not active when enabled");

endmodule : legacy_io_trap_capture

/* hdl/legacy_trap_cfg.svh */
`ifndef LEGACY_TRAP_CFG_SVH
`define LEGACY_TRAP_CFG_SVH

// Register word offset (byte address of the control/status register).
`define LEG_TRAP_OFFSET      8'h18

// Control field positions.
`define FAST_JOY_BIT         31
`define HOST_IRQ_BLOCK_BIT   30
`define GAME_RANGE_BIT       29
`define BASE_RANGE_HI        28
`define BASE_RANGE_LO        27
`define CODEC_RANGE_HI       26
`define CODEC_RANGE_LO       25
`define FORCE_IRQ_BIT        24
`define SLAVE_DMA_EN_BIT     23
`define SLAVE_INTC_EN_BIT    22
`define MASTER_DMA_EN_BIT    21
`define MASTER_INTC_EN_BIT   20
`define FM_EN_BIT            19
`define GAME_EN_BIT          18
`define CODEC_EN_BIT         17
`define BASE_EN_BIT          16

// Status field positions.
`define EVENT_HI             10
`define EVENT_LO             8
`define ADDR_HI              7
`define ADDR_LO              3
`define DIR_BIT              2
`define FLAG_BIT             0

// Reset values and fixed read fields.
`define CTRL_RESET           16'h0000
`define ONES_FIELD           5'h1F

// Event numbers.
`define EV_BASE              3'h0
`define EV_CODEC             3'h1
`define EV_GAME              3'h2
`define EV_FM                3'h3
`define EV_MASTER_INTC       3'h4
`define EV_MASTER_DMA        3'h5
`define EV_SLAVE_INTC        3'h6
`define EV_SLAVE_DMA         3'h7

// Trap window bounds, inclusive.
`define GAME_LO_0            16'h0220
`define GAME_HI_0            16'h022F
`define GAME_LO_1            16'h0240
`define GAME_HI_1            16'h024F
`define BASE_LO_0            16'h0320
`define BASE_LO_1            16'h0330
`define BASE_LO_3            16'h0350
`define BASE_STEP            16'h0010
`define BASE_SPAN            16'h0007
`define CODEC_LO_0           16'h0530
`define CODEC_LO_2           16'h0E80
`define CODEC_LO_3           16'h0F40
`define CODEC_SPAN           16'h0007
`define FM_LO                16'h0388
`define FM_HI                16'h038B
`define MINTC_LO             16'h0020
`define MINTC_HI             16'h0021
`define MDMA_LO              16'h0000
`define MDMA_HI              16'h000F
`define SINTC_LO             16'h00A0
`define SINTC_HI             16'h00A1
`define SDMA_LO              16'h00C0
`define SDMA_HI              16'h00DF

`endif

/* hdl/legacy_trap_pkg.sv */
package legacy_trap_pkg;
  typedef logic [2:0]  event_num_t;
  typedef logic [15:0] io_addr_t;
  typedef logic [31:0] word_t;
endpackage : legacy_trap_pkg

/* testbench/host_io_model.sv */
`timescale 1ns/10ps
module host_io_model (
  // Clock
  input  wire logic        mclk,
  // Snooped I/O cycle
  output logic             snoopValid,
  output logic [15:0]      snoopAddr,
  output logic             snoopWrite
);
  initial begin
    snoopValid = 1'b0;
    snoopAddr  = 16'hFFFF;
    snoopWrite = 1'b0;
  end

  // Between cycles the bridge does not hold the bus, so the inverse is
  // shown instead of a stale value that could be trapped by mistake.
  task automatic io_cycle(input logic [15:0] a, input logic w);
    @(posedge mclk);
    #1;
    snoopValid = 1'b1;
    snoopAddr  = a;
    snoopWrite = w;
    @(posedge mclk);
    #1;
    snoopValid = 1'b0;
    snoopAddr  = ~a;
    snoopWrite = ~w;
  endtask : io_cycle
endmodule : host_io_model

/* testbench/legacy_io_trap_capture_tb.sv */
`timescale 1ns/10ps
module legacy_io_trap_capture_tb;
  import legacy_trap_pkg::*;
  logic       mclk, rst_b, regWr, regRd, regRvalid, dmaConfigEnable;
  logic       snoopValid, snoopWrite, fastJoystick, hostIrqBlock, trapIrq_b;
  logic [7:0] regAddr;
  logic [3:0] regBe;
  word_t      regWdata, regRdata;
  io_addr_t   snoopAddr;
  int         errCount, testsRun;
  localparam int NW = 12;
  logic [15:0] ctl [NW] = '{16'h8801, 16'h1801, 16'h0002, 16'h0402,
    16'h0602, 16'h2004, 16'h4004, 16'h4008, 16'h0010, 16'h0020,
    16'h0040, 16'h0080};
  io_addr_t adr [NW] = '{16'h0330, 16'h0357, 16'h0537, 16'h0E80,
    16'h0F47, 16'h024F, 16'h0220, 16'h038B, 16'h0021, 16'h000F,
    16'h00A0, 16'h00DF};
  event_num_t evn [NW] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
    3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  always #2.5 mclk = ~mclk;

  legacy_io_trap_capture dut_u (.mclk(mclk), .rst_b(rst_b),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regBe(regBe),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .snoopValid(snoopValid), .snoopAddr(snoopAddr),
    .snoopWrite(snoopWrite), .dmaConfigEnable(dmaConfigEnable),
    .fastJoystick(fastJoystick), .hostIrqBlock(hostIrqBlock),
    .trapIrq_b(trapIrq_b));

  host_io_model host_u (.mclk(mclk), .snoopValid(snoopValid),
    .snoopAddr(snoopAddr), .snoopWrite(snoopWrite));

  task automatic chk(input string n, input word_t e, input word_t g);
    testsRun++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input word_t d,
                    input logic [3:0] be);
    @(posedge mclk);
    #1;
    regAddr  = a;
    regWdata = d;
    regBe    = be;
    regWr    = 1'b1;
    @(posedge mclk);
    #1;
    regWr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output word_t d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regRd   = 1'b1;
    @(posedge mclk);
    #1;
    regRd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, regRvalid});
    d = regRdata;
  endtask : rd

  task automatic t_reset;
    word_t d;
    rd(8'h18, d);
    chk("reset", 32'h0000_F801, d & 32'hFFFF_F803);
    chk("irq_idle", 32'h1, {31'h0, trapIrq_b});
  endtask : t_reset

  task automatic t_windows;
    word_t d;
    word_t e;
    for (int i = 0; i < NW; i++) begin
      dmaConfigEnable = i[0];
      wr(8'h18, {ctl[i], 16'h0000}, 4'hD);
      host_u.io_cycle(adr[i], i[1]);
      chk("irq", 32'h0, {31'h0, trapIrq_b});
      chk("fast", {31'h0, ctl[i][15]}, {31'h0, fastJoystick});
      chk("hib", {31'h0, ctl[i][14] & i[0]}, {31'h0, hostIrqBlock});
      rd(8'h18, d);
      e = {ctl[i], 5'h1F, evn[i], adr[i][4:0], i[1], 2'b00};
      chk("csr", e, d);
    end
  endtask : t_windows

  task automatic t_disabled;
    for (int i = 0; i < NW; i++) begin
      wr(8'h18, {ctl[i] & 16'hFF00, 16'h0000}, 4'hD);
      host_u.io_cycle(adr[i], 1'b1);
      chk("irq_off", 32'h1, {31'h0, trapIrq_b});
    end
    wr(8'h18, 32'h0202_0000, 4'hC);
    host_u.io_cycle(16'h0530, 1'b0);
    chk("codec01", 32'h1, {31'h0, trapIrq_b});
    wr(8'h18, 32'h2004_0000, 4'hC);
    host_u.io_cycle(16'h022F, 1'b0);
    chk("game_sel", 32'h1, {31'h0, trapIrq_b});
  endtask : t_disabled

  task automatic t_hold;
    word_t d;
    wr(8'h18, 32'h0018_0000, 4'hD);
    host_u.io_cycle(16'h0388, 1'b1);
    host_u.io_cycle(16'h0020, 1'b0);
    rd(8'h18, d);
    chk("hold", 32'h0018_FB44, d);
    wr(8'h18, 32'h0000_0000, 4'h1);
    rd(8'h18, d);
    chk("clear", 32'h0018_FB45, d);
  endtask : t_hold

  task automatic t_force;
    word_t d;
    wr(8'h18, 32'h0100_0000, 4'h8);
    chk("force_irq", 32'h0, {31'h0, trapIrq_b});
    rd(8'h18, d);
    chk("force", 32'h0100_0000, d & 32'hFF00_0003);
    wr(8'h18, 32'hFFFF_FFFF, 4'h1);
    rd(8'h18, d);
    chk("unforce", 32'h0100_0001, d & 32'hFF00_0003);
  endtask : t_force

  task automatic t_unmapped;
    word_t d;
    rd(8'h1C, d);
    chk("unmap_rd", 32'h0, d);
    wr(8'h14, 32'hFFFF_FFFF, 4'hF);
    rd(8'h18, d);
    chk("unmap_wr", 32'h0100_0001, d & 32'hFF00_0003);
  endtask : t_unmapped

  task automatic stop_test;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regBe = 4'h0;
    regWdata = 32'h0;
    dmaConfigEnable = 1'b0;
    errCount = 0;
    testsRun = 0;
    repeat (20) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_windows();
    t_disabled();
    t_hold();
    t_force();
    t_unmapped();
    stop_test();
  end
endmodule : legacy_io_trap_capture_tb
